// ===== include/cmtc_consts.vh
`ifndef CMTC_CONSTS_VH
`define CMTC_CONSTS_VH
`define CMTC_NUM_MB        16
`define CMTC_MB_IDX_W      4
`define CMTC_ADDR_W        8
`define CMTC_CODE_W        4
`define CMTC_CODE_LSB      24
`define CMTC_CODE_MSB      27
`define CMTC_DLC_LSB       16
`define CMTC_DLC_MSB       19
`define CMTC_CODE_ZERO     4'h0
`define CMTC_CODE_INACTIVE 4'h8
`define CMTC_CODE_ABORT    4'h9
`define CMTC_CODE_TX       4'hC
`define CMTC_CS_RST        32'h08000000
`define CMTC_ADDR_CFG      8'h00
`define CMTC_ADDR_FLAG     8'h04
`define CMTC_ADDR_MASK     8'h08
`define CMTC_ADDR_STAT     8'h0C
`define CMTC_ADDR_MB_BASE  8'h40
`define CMTC_MB_WORDS      4
`define CMTC_CFG_ABORT_EN  0
`define CMTC_CFG_RST       32'h00000000
`define CMTC_BUSY_TIME_NS  20000
`define CMTC_CLK_PERIOD_NS 100
`define CMTC_BUSY_CYCLES   (`CMTC_BUSY_TIME_NS / `CMTC_CLK_PERIOD_NS)
`endif

// ===== src/cmtc_sync.v
/*
  Three-stage pin synchroniser with agreement of the last two stages.
  Assumes an asynchronous input and the core clock domain.
*/
`include "cmtc_consts.vh"
module cmtc_sync (
  // Clock and reset.
  input  wire core_clk,
  input  wire rst_n,
  // Pin and result.
  input  wire pin_in,
  output reg  level_out
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r      <= 1'b0;
      s2_r      <= 1'b0;
      s3_r      <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule

// ===== src/cmtc_arb.v
/*
  Arbitration scanner: walks the buffers one per clock and keeps the
  lowest-index buffer holding the transmit-request code.
  Assumes a code vector from the register file on the same clock.
*/
`include "cmtc_consts.vh"
module cmtc_arb (
  // Clock and reset.
  input  wire                                   core_clk,
  input  wire                                   rst_n,
  // Control.
  input  wire                                   scan_start,
  input  wire [`CMTC_NUM_MB*`CMTC_CODE_W-1:0]   codes,
  // Result.
  output reg                                    scan_busy,
  output reg                                    scan_done,
  output reg                                    win_valid,
  output reg  [`CMTC_MB_IDX_W-1:0]              win_idx,
  output reg  [`CMTC_MB_IDX_W-1:0]              scan_pos
);
  wire [`CMTC_CODE_W-1:0] cur_code;
  assign cur_code = codes[scan_pos*`CMTC_CODE_W +: `CMTC_CODE_W];
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_busy <= 1'b0;
      scan_done <= 1'b0;
      win_valid <= 1'b0;
      win_idx   <= 4'h0;
      scan_pos  <= 4'h0;
    end else begin
      scan_done <= 1'b0;
      if (scan_start) begin
        scan_busy <= 1'b1;
        win_valid <= 1'b0;
        scan_pos  <= 4'h0;
      end else if (scan_busy) begin
        if (cur_code == `CMTC_CODE_TX && !win_valid) begin
          win_valid <= 1'b1;
          win_idx   <= scan_pos;
        end
        if (scan_pos == 4'hF) begin
          scan_busy <= 1'b0;
          scan_done <= 1'b1;
        end else begin
          scan_pos <= scan_pos + 4'h1;
        end
      end
    end
  end
endmodule

// ===== src/cmtc_top.v
/*
  Transmit mailbox control: buffer words, state fields, arbitration
  scheduling, event flags, mask and interrupt.
  Assumes a single-cycle register port and an abstract frame engine on
  the pins: tx_start out, tx_done, rx_sof and intermission_end in.
*/
// The plain strobed port and the register offsets were left to the implementer.
// How it works
// - Abort sets the buffer event flag; unmasked flags raise the interrupt.
// - After abort, the state field reads inactive whether the frame was aborted or transmitted.
// - Abort disabled: inactive write deactivates; pending frame may still go, silently.
// - Writing the transmit-request code schedules the buffer for arbitration.
// - Writing zero to the state field deactivates the buffer.
// - A state write landing at or behind the scan position during a scan triggers a rescan.
// - The first state write or foreign frame start after intermission forces a rescan.
`include "cmtc_consts.vh"
module cmtc_top (
  // Clock and reset.
  input  wire                      core_clk,
  input  wire                      rst_n,
  // Register port.
  input  wire [`CMTC_ADDR_W-1:0]   reg_addr,
  input  wire [31:0]               reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [31:0]               reg_rdata,
  // Frame engine pins.
  input  wire                      tx_done_pin,
  input  wire                      rx_sof_pin,
  input  wire                      intermission_end_pin,
  output reg                       tx_start,
  output reg  [`CMTC_MB_IDX_W-1:0] tx_mb_idx,
  // Interrupt.
  output reg                       irq
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SCAN = 3'b010;
  localparam ST_TX   = 3'b100;
  // The abort timeout runs from the start pulse, so a late abort gives up sooner.
  localparam [31:0] BUSY_FULL = `CMTC_BUSY_CYCLES;

  reg  [31:0] mb_mem [0:`CMTC_NUM_MB*`CMTC_MB_WORDS-1];
  reg  [`CMTC_CODE_W-1:0] code_r [0:`CMTC_NUM_MB-1];
  reg  [31:0] cfg_r;
  reg  [15:0] flag_r;
  reg  [15:0] mask_r;
  reg  [2:0]  state_r;
  reg         rescan_r;
  reg         abort_pend_r;
  reg         after_im_r;
  reg  [`CMTC_MB_IDX_W-1:0] cur_idx_r;
  reg  [15:0] busy_cnt_r;

  wire tx_done;
  wire rx_sof;
  wire im_end;
  reg  tx_done_d_r;
  reg  rx_sof_d_r;
  reg  im_end_d_r;

  wire [`CMTC_NUM_MB*`CMTC_CODE_W-1:0] codes;
  wire scan_busy;
  wire scan_done;
  wire win_valid;
  wire [`CMTC_MB_IDX_W-1:0] win_idx;
  wire [`CMTC_MB_IDX_W-1:0] scan_pos;
  reg  scan_start;

  genvar g;
  generate
    for (g = 0; g < `CMTC_NUM_MB; g = g + 1) begin : g_codes
      assign codes[g*`CMTC_CODE_W +: `CMTC_CODE_W] = code_r[g];
    end
  endgenerate

  // Decodes a buffer word address; valid when inside the buffer window.
  function is_mb;
    input [`CMTC_ADDR_W-1:0] a;
    begin
      is_mb = (a >= `CMTC_ADDR_MB_BASE) && (a[1:0] == 2'b00);
    end
  endfunction

  // Buffers above eleven lie beyond the byte address space; they are scanned only.
  wire [`CMTC_ADDR_W-1:0] mb_off = reg_addr - `CMTC_ADDR_MB_BASE;
  wire [5:0] mb_word = mb_off[7:2];
  wire [`CMTC_MB_IDX_W-1:0] wr_mb = mb_word[5:2];
  wire cs_wr = reg_wr && is_mb(reg_addr) && (mb_word[1:0] == 2'b00);
  wire [`CMTC_CODE_W-1:0] wr_code = reg_wdata[`CMTC_CODE_MSB:`CMTC_CODE_LSB];
  wire abort_en = cfg_r[`CMTC_CFG_ABORT_EN];
  // Only the buffer on the bus can hold an abort open; others finish at once.
  wire wr_is_sending = (state_r == ST_TX) && (cur_idx_r == wr_mb);

  wire tx_edge = tx_done & ~tx_done_d_r;
  wire sof_edge = rx_sof & ~rx_sof_d_r;
  wire im_edge = im_end & ~im_end_d_r;

  cmtc_sync u_sync_done (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pin_in    (tx_done_pin),
    .level_out (tx_done)
  );
  cmtc_sync u_sync_sof (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pin_in    (rx_sof_pin),
    .level_out (rx_sof)
  );
  cmtc_sync u_sync_im (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pin_in    (intermission_end_pin),
    .level_out (im_end)
  );

  cmtc_arb u_arb (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .scan_start (scan_start),
    .codes      (codes),
    .scan_busy  (scan_busy),
    .scan_done  (scan_done),
    .win_valid  (win_valid),
    .win_idx    (win_idx),
    .scan_pos   (scan_pos)
  );

  // Register file, buffer memory and event flags.
  integer i;
  reg [15:0] flag_set;
  always @* begin
    flag_set = 16'h0000;
    // A buffer deactivated while on the bus finishes silently.
    if (state_r == ST_TX && tx_edge && code_r[cur_idx_r] != `CMTC_CODE_INACTIVE &&
        code_r[cur_idx_r] != `CMTC_CODE_ZERO) begin
      flag_set[cur_idx_r] = 1'b1;
    end
    if (cs_wr && abort_en && wr_code == `CMTC_CODE_ABORT && !wr_is_sending) begin
      flag_set[wr_mb] = 1'b1;
    end
    if (state_r == ST_TX && abort_pend_r && !tx_edge && busy_cnt_r == 16'h0000) begin
      flag_set[cur_idx_r] = 1'b1;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r  <= `CMTC_CFG_RST;
      flag_r <= 16'h0000;
      mask_r <= 16'h0000;
      for (i = 0; i < `CMTC_NUM_MB; i = i + 1) begin
        code_r[i] <= `CMTC_CODE_INACTIVE;
      end
    end else begin
      // Hardware set beats a simultaneous write-one clear.
      flag_r <= (flag_r & ~((reg_wr && reg_addr == `CMTC_ADDR_FLAG) ?
                reg_wdata[15:0] : 16'h0000)) | flag_set;
      if (reg_wr && reg_addr == `CMTC_ADDR_CFG) begin
        cfg_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `CMTC_ADDR_MASK) begin
        mask_r <= reg_wdata[15:0];
      end
      if (cs_wr) begin
        if (wr_code == `CMTC_CODE_ABORT && !abort_en) begin
          code_r[wr_mb] <= `CMTC_CODE_INACTIVE;
        end else if (wr_code == `CMTC_CODE_ABORT &&
                     !wr_is_sending) begin
          code_r[wr_mb] <= `CMTC_CODE_INACTIVE;
        end else if (!(wr_code == `CMTC_CODE_ABORT && state_r == ST_TX &&
                       cur_idx_r == wr_mb)) begin
          code_r[wr_mb] <= wr_code;
        end else begin
          code_r[wr_mb] <= `CMTC_CODE_ABORT;
        end
      end
      if (state_r == ST_TX && tx_edge) begin
        code_r[cur_idx_r] <= `CMTC_CODE_INACTIVE;
      end else if (state_r == ST_TX && abort_pend_r && busy_cnt_r == 16'h0000) begin
        code_r[cur_idx_r] <= `CMTC_CODE_INACTIVE;
      end
    end
  end

  always @(posedge core_clk) begin
    if (reg_wr && is_mb(reg_addr)) begin
      mb_mem[mb_word] <= reg_wdata;
    end
  end

  // Scheduling: scan, then hand the winner to the frame engine.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= ST_IDLE;
      rescan_r     <= 1'b0;
      scan_start   <= 1'b0;
      tx_start     <= 1'b0;
      tx_mb_idx    <= 4'h0;
      cur_idx_r    <= 4'h0;
      abort_pend_r <= 1'b0;
      after_im_r   <= 1'b0;
      busy_cnt_r   <= 16'h0000;
      tx_done_d_r  <= 1'b0;
      rx_sof_d_r   <= 1'b0;
      im_end_d_r   <= 1'b0;
    end else begin
      tx_done_d_r <= tx_done;
      rx_sof_d_r  <= rx_sof;
      im_end_d_r  <= im_end;
      scan_start  <= 1'b0;
      tx_start    <= 1'b0;
      if (cs_wr && wr_code == `CMTC_CODE_TX) begin
        rescan_r <= 1'b1;
      end
      if (cs_wr && scan_busy && wr_mb <= scan_pos) begin
        rescan_r <= 1'b1;
      end
      // Intermission end opens a window that the next state write or foreign start closes.
      if (im_edge) begin
        after_im_r <= 1'b1;
      end else if (cs_wr || sof_edge) begin
        after_im_r <= 1'b0;
      end
      if ((im_edge || after_im_r) && (cs_wr || sof_edge)) begin
        rescan_r <= 1'b1;
      end
      if (cs_wr && state_r == ST_TX && wr_mb == cur_idx_r &&
          wr_code == `CMTC_CODE_ABORT && abort_en) begin
        abort_pend_r <= 1'b1;
      end
      case (state_r)
        ST_IDLE: begin
          if (rescan_r) begin
            rescan_r   <= 1'b0;
            scan_start <= 1'b1;
            state_r    <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (scan_done) begin
            if (win_valid && code_r[win_idx] == `CMTC_CODE_TX) begin
              cur_idx_r  <= win_idx;
              tx_mb_idx  <= win_idx;
              tx_start   <= 1'b1;
              busy_cnt_r <= BUSY_FULL[15:0];
              state_r    <= ST_TX;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_TX: begin
          if (busy_cnt_r != 16'h0000) begin
            busy_cnt_r <= busy_cnt_r - 16'h0001;
          end
          if (tx_edge || (abort_pend_r && busy_cnt_r == 16'h0000)) begin
            abort_pend_r <= 1'b0;
            rescan_r     <= 1'b1;
            state_r      <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Read port and interrupt.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
      irq       <= 1'b0;
    end else begin
      irq <= |(flag_r & mask_r);
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        if (reg_addr == `CMTC_ADDR_CFG) begin
          reg_rdata <= cfg_r;
        end else if (reg_addr == `CMTC_ADDR_FLAG) begin
          reg_rdata <= {16'h0000, flag_r};
        end else if (reg_addr == `CMTC_ADDR_MASK) begin
          reg_rdata <= {16'h0000, mask_r};
        end else if (reg_addr == `CMTC_ADDR_STAT) begin
          reg_rdata <= {20'h00000, cur_idx_r, 5'h00, state_r};
        end else if (is_mb(reg_addr)) begin
          if (mb_word[1:0] == 2'b00) begin
            reg_rdata <= {mb_mem[mb_word][31:28], code_r[wr_mb],
                          mb_mem[mb_word][23:0]};
          end else begin
            reg_rdata <= mb_mem[mb_word];
          end
        end
      end
    end
  end
endmodule

// ===== verif/cmtc_top_assertions.sv
/*
  Checker on the ports of the transmit mailbox control block.
  Assumes one core clock and the async active-low reset.
*/
`include "cmtc_consts.vh"
module cmtc_top_checker (
  // Clock and reset.
  input wire                      core_clk,
  input wire                      rst_n,
  // Register port.
  input wire [`CMTC_ADDR_W-1:0]   reg_addr,
  input wire [31:0]               reg_wdata,
  input wire                      reg_wr,
  input wire                      reg_rd,
  input wire [31:0]               reg_rdata,
  // Frame engine pins.
  input wire                      tx_done_pin,
  input wire                      rx_sof_pin,
  input wire                      intermission_end_pin,
  input wire                      tx_start,
  input wire [`CMTC_MB_IDX_W-1:0] tx_mb_idx,
  // Interrupt.
  input wire                      irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Age starts saturated so the very first start is not judged as a repeat.
  reg [8:0] age_r;
  reg [8:0] quiet_r;
  reg       done_r;
  reg       armed_r;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      age_r <= 9'h1FF;
      quiet_r <= 9'h000;
      done_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      age_r <= tx_start ? 9'h000 : age_r + {8'h00, age_r != 9'h1FF};
      quiet_r <= (reg_wr || tx_done_pin) ? 9'h000 : quiet_r + {8'h00, quiet_r != 9'h1FF};
      done_r <= !tx_start && (done_r || tx_done_pin);
      armed_r <= armed_r || (reg_wr && reg_wdata[27:24] == `CMTC_CODE_TX);
    end
  end
  idx_hold_a: assert property (!tx_start |-> $stable(tx_mb_idx))
    else $error("buffer index moved without a start");
  start_spacing_a: assert property (tx_start |=> !tx_start [*8])
    else $error("start pulses too close");
  start_refused_a: assert property (tx_start |-> done_r || age_r >= 9'd200)
    else $error("start before frame end or abort timeout");
  start_armed_a: assert property (tx_start |-> armed_r)
    else $error("start with no transmit request written");
  irq_cause_a: assert property ($rose(irq) |-> quiet_r < 9'd230)
    else $error("interrupt rose with no event");
  irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt fell with no write");
  irq_hold_a: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
    else $error("interrupt dropped by itself");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");
  cover property (tx_start);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule
bind cmtc_top cmtc_top_checker cmtc_top_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tx_done_pin(tx_done_pin), .rx_sof_pin(rx_sof_pin),
  .intermission_end_pin(intermission_end_pin), .tx_start(tx_start),
  .tx_mb_idx(tx_mb_idx), .irq(irq));

// ===== verif/cmtc_far_node.sv
/*
  Frame engine and other bus nodes seen from the block's pins.
  Assumes the block's core clock; pins idle low between frames.
*/
module cmtc_far_node (
  // Clock and control.
  input  wire core_clk,
  input  wire mute,
  input  wire sof_req,
  // Frame engine pins.
  input  wire tx_start,
  output reg  tx_done_pin,
  output reg  rx_sof_pin,
  output reg  intermission_end_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tx_done_pin = 1'b0;
    rx_sof_pin = 1'b0;
    intermission_end_pin = 1'b0;
  end
  // A muted node never ends the frame, so only the abort timeout frees it.
  always @(posedge core_clk) begin
    if (tx_start && !mute) begin
      repeat (10) @(posedge core_clk);
      tx_done_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      tx_done_pin <= 1'b0;
      intermission_end_pin <= 1'b1;
      repeat (6) @(posedge core_clk);
      intermission_end_pin <= 1'b0;
    end
  end
  always @(posedge core_clk) rx_sof_pin <= sof_req;
endmodule

// ===== verif/cmtc_top_test.sv
/*
  Self-checking bench of the transmit mailbox control block.
  Assumes the far node model and the bound checker.
*/
`include "cmtc_consts.vh"
module cmtc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  reg core_clk, rst_n, reg_wr, reg_rd, mute, sof_req;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata;
  wire [31:0] reg_rdata;
  wire tx_done_pin, rx_sof_pin, intermission_end_pin, tx_start, irq;
  wire [3:0] tx_mb_idx;
  integer n_mismatch, tests_run;
  cmtc_top cmtc_top_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_done_pin(tx_done_pin), .rx_sof_pin(rx_sof_pin),
    .intermission_end_pin(intermission_end_pin), .tx_start(tx_start),
    .tx_mb_idx(tx_mb_idx), .irq(irq));
  cmtc_far_node cmtc_far_node_inst (.core_clk(core_clk), .mute(mute), .sof_req(sof_req),
    .tx_start(tx_start), .tx_done_pin(tx_done_pin), .rx_sof_pin(rx_sof_pin),
    .intermission_end_pin(intermission_end_pin));
  always #50 core_clk = !core_clk;
  function [7:0] mb(input [3:0] n, input [1:0] w);
    mb = `CMTC_ADDR_MB_BASE + {n, w, 2'b00};
  endfunction
  function [31:0] cs(input [3:0] code);
    cs = {4'h0, code, 24'h080000};
  endfunction
  task test_done;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] v);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask
  task rc(input [7:0] a, input [31:0] exp);
    reg [31:0] v;
    begin
      rd(a, v);
      chk(v, exp);
    end
  endtask
  task rcode(input [3:0] n, input [3:0] exp);
    reg [31:0] v;
    begin
      rd(mb(n, 2'd0), v);
      chk({28'h0, v[27:24]}, {28'h0, exp});
    end
  endtask
  // Waits for a pin with a bounded count; running out ends the run.
  task wait_hi(input integer which, input [3:0] idx);
    integer i;
    reg seen;
    begin
      seen = 1'b0;
      for (i = 0; i < 400 && !seen; i = i + 1) begin
        @(posedge core_clk);
        #1 seen = (which == 0) ? (tx_start === 1'b1) : (irq === 1'b1);
      end
      if (!seen) begin
        n_mismatch = n_mismatch + 1;
        test_done;
      end else if (which == 0) begin
        chk({28'h0, tx_mb_idx}, {28'h0, idx});
      end
    end
  endtask
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, mute, sof_req} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    n_mismatch = 0;
    tests_run = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rc(`CMTC_ADDR_CFG, `CMTC_CFG_RST);
    rc(`CMTC_ADDR_FLAG, 32'h0);
    rc(`CMTC_ADDR_MASK, 32'h0);
    rc(mb(4'd0, 2'd0), `CMTC_CS_RST);
    rc(8'h30, 32'h0);
    rc(`CMTC_ADDR_STAT, 32'h1);
    // One frame from buffer 3, prepared in the documented order.
    wr(`CMTC_ADDR_MASK, 32'h8);
    wr(mb(4'd3, 2'd1), 32'h12345678);
    wr(mb(4'd3, 2'd2), 32'hA5A5A5A5);
    wr(mb(4'd3, 2'd3), 32'h5A5A5A5A);
    wr(mb(4'd3, 2'd0), cs(`CMTC_CODE_TX));
    wr(mb(4'd0, 2'd0), cs(`CMTC_CODE_INACTIVE));
    wr(mb(4'd0, 2'd0), cs(`CMTC_CODE_INACTIVE));
    wait_hi(0, 4'd3);
    wait_hi(1, 4'd0);
    rc(`CMTC_ADDR_FLAG, 32'h8);
    rcode(4'd3, `CMTC_CODE_INACTIVE);
    rcode(4'd0, `CMTC_CODE_INACTIVE);
    wr(`CMTC_ADDR_FLAG, 32'h8);
    rc(`CMTC_ADDR_FLAG, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // A lower buffer activated during the scan must still win.
    wr(mb(4'd5, 2'd0), cs(`CMTC_CODE_TX));
    wr(mb(4'd2, 2'd0), cs(`CMTC_CODE_TX));
    wait_hi(0, 4'd2);
    wr(`CMTC_ADDR_MASK, 32'h20);
    wait_hi(0, 4'd5);
    wait_hi(1, 4'd0);
    rc(`CMTC_ADDR_FLAG, 32'h24);
    wr(`CMTC_ADDR_FLAG, 32'h24);
    wr(`CMTC_ADDR_MASK, 32'h0);
    // Aborts of a waiting buffer and of the buffer on the bus.
    wr(`CMTC_ADDR_CFG, 32'h1);
    mute <= 1'b1;
    wr(mb(4'd1, 2'd0), cs(`CMTC_CODE_TX));
    wait_hi(0, 4'd1);
    wr(mb(4'd7, 2'd0), cs(`CMTC_CODE_TX));
    wr(mb(4'd7, 2'd0), cs(`CMTC_CODE_ABORT));
    rc(`CMTC_ADDR_FLAG, 32'h80);
    rcode(4'd7, `CMTC_CODE_INACTIVE);
    chk({31'h0, irq}, 32'h0);
    wr(mb(4'd1, 2'd0), cs(`CMTC_CODE_ABORT));
    rcode(4'd1, `CMTC_CODE_ABORT);
    wr(`CMTC_ADDR_MASK, 32'h2);
    wait_hi(1, 4'd0);
    rc(`CMTC_ADDR_FLAG, 32'h82);
    rcode(4'd1, `CMTC_CODE_INACTIVE);
    wr(`CMTC_ADDR_FLAG, 32'h82);
    // Abort disabled: an inactive write on the sending buffer stays silent.
    wr(`CMTC_ADDR_CFG, 32'h0);
    mute <= 1'b0;
    wr(mb(4'd2, 2'd0), cs(`CMTC_CODE_TX));
    wait_hi(0, 4'd2);
    wr(mb(4'd2, 2'd0), cs(`CMTC_CODE_INACTIVE));
    rcode(4'd2, `CMTC_CODE_INACTIVE);
    // Deactivate with zero, then rearm while a foreign frame starts.
    wr(mb(4'd4, 2'd0), cs(`CMTC_CODE_ZERO));
    rcode(4'd4, `CMTC_CODE_ZERO);
    sof_req <= 1'b1;
    wr(mb(4'd4, 2'd0), cs(`CMTC_CODE_TX));
    sof_req <= 1'b0;
    wait_hi(0, 4'd4);
    rc(`CMTC_ADDR_FLAG, 32'h0);
    rcode(4'd0, `CMTC_CODE_INACTIVE);
    test_done;
  end
endmodule
